// ===== stpe_pkg.sv
package stpe_pkg;
   // register byte addresses
   localparam logic [31:0] ADDR_ROW_COLUMN = 32'hffffe80c;
   localparam logic [31:0] ADDR_REFRESH_EXIT = 32'hffffe810;
   localparam logic [31:0] ADDR_POWERDOWN_WINDOW = 32'hffffe814;
   localparam logic [31:0] ADDR_CONTROL = 32'hffffe840;
   localparam logic [31:0] ADDR_STATUS = 32'hffffe844;
   // reset values and writable masks
   localparam logic [31:0] RST_ROW_COLUMN = 32'h20227225;
   localparam logic [31:0] RST_REFRESH_EXIT = 32'h03c80808;
   localparam logic [31:0] RST_POWERDOWN_WINDOW = 32'h00042062;
   localparam logic [31:0] RST_CONTROL = 32'h00000200;
   localparam logic [31:0] MASK_ROW_COLUMN = 32'hffffffff;
   localparam logic [31:0] MASK_REFRESH_EXIT = 32'h0fffff1f;
   localparam logic [31:0] MASK_POWERDOWN_WINDOW = 32'h000f7fff;
   localparam logic [31:0] MASK_CONTROL = 32'h00010371;
   // row/column register fields (lsb positions)
   localparam int F_ACT_TO_PRE = 0;
   localparam int F_ROW_TO_COL = 4;
   localparam int F_WRITE_RECOVERY = 8;
   localparam int F_ACT_TO_REFRESH = 12;
   localparam int F_PRECHARGE_RECOVERY = 16;
   localparam int F_BANK_TO_BANK = 20;
   localparam int F_INTERNAL_WR_TO_RD = 24;
   localparam int F_SHORTEN_WR_RD = 27;
   localparam int F_MODE_LOAD = 28;
   // refresh/exit register fields
   localparam int F_REFRESH_CYCLE = 0;
   localparam int F_SELFREF_NONREAD = 8;
   localparam int F_SELFREF_READ = 16;
   localparam int F_POWERDOWN_EXIT = 24;
   // powerdown/window register fields
   localparam int F_APD_FAST = 0;
   localparam int F_APD_SLOW = 4;
   localparam int F_PRECHARGE_ALL = 8;
   localparam int F_READ_TO_PRE = 12;
   localparam int F_FOUR_ACT = 16;
   // control register fields
   localparam int F_INTERLEAVE = 0;
   localparam int F_MEM_TYPE = 4;
   localparam int F_EIGHT_BANKS = 8;
   localparam int F_APD_SLOW_SEL = 9;
   localparam int F_WRITE_PROTECT = 16;
   // memory type codes
   localparam logic [2:0] MT_SDR = 3'h0;
   localparam logic [2:0] MT_LPSDR = 3'h1;
   localparam logic [2:0] MT_LPDDR1 = 3'h3;
   localparam logic [2:0] MT_DDR2 = 3'h4;
   // scheduler command codes
   typedef enum logic [2:0] {
      CMD_NOP = 3'h0, CMD_ACTIVATE = 3'h1, CMD_READ = 3'h2, CMD_WRITE = 3'h3,
      CMD_PRECHARGE = 3'h4, CMD_PRECHARGE_ALL = 3'h5, CMD_REFRESH = 3'h6,
      CMD_MODE_LOAD = 3'h7
   } stpe_cmd_t;
   // clock-enable exit kinds
   localparam logic [1:0] EXIT_SELFREF = 2'h0;
   localparam logic [1:0] EXIT_POWERDOWN = 2'h1;
   // global spacing counter indices
   localparam int G_RP = 0;
   localparam int G_RPA = 1;
   localparam int G_RRD = 2;
   localparam int G_RC = 3;
   localparam int G_MRD = 4;
   localparam int G_RFC = 5;
   localparam int G_XSNR = 6;
   localparam int G_XSRD = 7;
   localparam int G_XP = 8;
   localparam int G_XARD = 9;
   localparam int G_WTR = 10;
   localparam int G_NUM = 11;
   // per-bank counter indices
   localparam int B_RAS = 0;
   localparam int B_RCD = 1;
   localparam int B_WR = 2;
   localparam int B_RTP = 3;
   localparam int B_NUM = 4;
   localparam int NUM_BANKS = 8;
   localparam int FAW_SLOTS = 4;
   // default write-to-read gap for low-power ddr/ddr2 when the field is zero and not shortened
   localparam logic [7:0] WTR_DEFAULT = 8'h01;
endpackage

// ===== stpe_timing_enforcer.sv
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - one bit picks sequential or interleaved decoding
// - timing register writes ignored while protected
// - activate to precharge spacing per bank
// - activate to read or write spacing
// - write recovery before precharge
// - activate to refresh spacing
// - precharge blocks every command for count
// - activate to activate spacing across banks
// - write to read gap on low-power ddr/ddr2
// - shorten write to read on low-power ddr when field zero
// - mode load blocks activate and refresh
// - refresh blocks activate and refresh
// - self refresh exit delays non-read commands
// - self refresh exit delays reads on ddr
// - power-down exit delays first command on low-power ddr/ddr2
// - fast active power-down exit delays read on ddr2
// - slow active power-down exit delays read on ddr2
// - precharge all blocks every command on ddr2
// - read to precharge spacing per bank
// - at most four activates per window on eight-bank ddr2
// - memory type code selects applicable fields
module stpe_timing_enforcer
   import stpe_pkg::*;
(
   // clock and reset
   input wire logic CLK_IN,
   input wire logic RST_IN,
   // wishbone slave
   input wire logic [31:0] WB_ADR_IN,
   input wire logic [31:0] WB_DAT_IN,
   input wire logic [3:0] WB_SEL_IN,
   input wire logic WB_WE_IN,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   output logic [31:0] WB_DAT_OUT,
   output logic WB_ACK_OUT,
   // issued commands from the scheduler
   input wire logic CMD_VALID_IN,
   input wire logic [2:0] CMD_IN,
   input wire logic [2:0] BANK_IN,
   input wire logic CKE_RISE_IN,
   input wire logic [1:0] EXIT_KIND_IN,
   // permissions back to the scheduler
   output logic [7:0] ALLOW_ACT_OUT,
   output logic [7:0] ALLOW_RD_OUT,
   output logic [7:0] ALLOW_WR_OUT,
   output logic [7:0] ALLOW_PRE_OUT,
   output logic ALLOW_PREALL_OUT,
   output logic ALLOW_REF_OUT,
   output logic ALLOW_MRS_OUT,
   // configuration seen by the rest of the controller
   output logic ADDR_INTERLEAVE_OUT,
   output logic [2:0] MEM_TYPE_OUT
);

   ////////////////////////////////////////////////////////////////////////////////
   // register file

   logic [31:0] row_column;
   logic [31:0] refresh_exit;
   logic [31:0] powerdown_window;
   logic [31:0] control;
   logic [31:0] status;
   logic [31:0] lane_mask;
   logic wb_req;
   logic wr_req;
   logic write_protect_enable;

   assign wb_req = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
   assign wr_req = wb_req & WB_WE_IN;
   assign lane_mask = {{8{WB_SEL_IN[3]}}, {8{WB_SEL_IN[2]}}, {8{WB_SEL_IN[1]}},
                       {8{WB_SEL_IN[0]}}};
   assign write_protect_enable = control[F_WRITE_PROTECT];

   // merge of written lanes into a register under its writable mask
   function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] wmask);
      merge = (cur & ~(lane_mask & wmask)) | (WB_DAT_IN & lane_mask & wmask);
   endfunction

   // timing registers, frozen while protection is on
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         row_column <= RST_ROW_COLUMN;
         refresh_exit <= RST_REFRESH_EXIT;
         powerdown_window <= RST_POWERDOWN_WINDOW;
      end else if (wr_req && !write_protect_enable) begin
         if (WB_ADR_IN == ADDR_ROW_COLUMN) begin
            row_column <= merge(row_column, MASK_ROW_COLUMN);
         end
         if (WB_ADR_IN == ADDR_REFRESH_EXIT) begin
            refresh_exit <= merge(refresh_exit, MASK_REFRESH_EXIT);
         end
         if (WB_ADR_IN == ADDR_POWERDOWN_WINDOW) begin
            powerdown_window <= merge(powerdown_window, MASK_POWERDOWN_WINDOW);
         end
      end
   end

   // control stays writable so protection can always be lifted again
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         control <= RST_CONTROL;
      end else if (wr_req && WB_ADR_IN == ADDR_CONTROL) begin
         control <= merge(control, MASK_CONTROL);
      end
   end

   // single wait state answer; unmapped reads give zero
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         WB_ACK_OUT <= 1'b0;
         WB_DAT_OUT <= 32'h00000000;
      end else begin
         WB_ACK_OUT <= wb_req;
         if (wb_req && !WB_WE_IN) begin
            case (WB_ADR_IN)
               ADDR_ROW_COLUMN: WB_DAT_OUT <= row_column;
               ADDR_REFRESH_EXIT: WB_DAT_OUT <= refresh_exit;
               ADDR_POWERDOWN_WINDOW: WB_DAT_OUT <= powerdown_window;
               ADDR_CONTROL: WB_DAT_OUT <= control;
               ADDR_STATUS: WB_DAT_OUT <= status;
               default: WB_DAT_OUT <= 32'h00000000;
            endcase
         end else begin
            WB_DAT_OUT <= 32'h00000000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // field decode

   logic [2:0] memory_type_code;
   logic lp_or_ddr2;
   logic is_ddr2;
   logic faw_enable;
   logic is_act;
   logic is_rd;
   logic is_wr;
   logic is_pre;
   logic is_preall;
   logic is_ref;
   logic is_mrs;
   logic sr_exit;
   logic pd_exit;

   assign memory_type_code = control[F_MEM_TYPE +: 3];
   assign lp_or_ddr2 = (memory_type_code == MT_LPDDR1) || (memory_type_code == MT_DDR2);
   assign is_ddr2 = (memory_type_code == MT_DDR2);
   assign faw_enable = is_ddr2 & control[F_EIGHT_BANKS];

   assign is_act = CMD_VALID_IN && CMD_IN == CMD_ACTIVATE;
   assign is_rd = CMD_VALID_IN && CMD_IN == CMD_READ;
   assign is_wr = CMD_VALID_IN && CMD_IN == CMD_WRITE;
   assign is_pre = CMD_VALID_IN && CMD_IN == CMD_PRECHARGE;
   assign is_preall = CMD_VALID_IN && CMD_IN == CMD_PRECHARGE_ALL;
   assign is_ref = CMD_VALID_IN && CMD_IN == CMD_REFRESH;
   assign is_mrs = CMD_VALID_IN && CMD_IN == CMD_MODE_LOAD;
   assign sr_exit = CKE_RISE_IN && EXIT_KIND_IN == EXIT_SELFREF;
   assign pd_exit = CKE_RISE_IN && EXIT_KIND_IN == EXIT_POWERDOWN;

   function automatic logic [7:0] count_next(input logic [7:0] cur, input logic load,
                                             input logic [7:0] val);
      logic [7:0] dec;
      dec = (cur != 8'h00) ? cur - 8'h01 : 8'h00;
      count_next = (load && val > dec) ? val : dec;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // global spacing counters

   logic [7:0] gcnt [G_NUM];
   logic [7:0] gnext [G_NUM];
   logic [7:0] gval [G_NUM];
   logic gload [G_NUM];
   logic [7:0] wtr_gap;

   always_comb begin
      if (row_column[F_INTERNAL_WR_TO_RD +: 3] != 3'h0) begin
         wtr_gap = {5'h00, row_column[F_INTERNAL_WR_TO_RD +: 3]};
      end else if (row_column[F_SHORTEN_WR_RD] && memory_type_code == MT_LPDDR1) begin
         wtr_gap = 8'h00;
      end else begin
         wtr_gap = WTR_DEFAULT;
      end
   end

   // load conditions and values; a precharge all on non-ddr2 parts uses row precharge
   always_comb begin
      gload[G_RP] = is_pre | (is_preall & ~is_ddr2);
      gval[G_RP] = {4'h0, row_column[F_PRECHARGE_RECOVERY +: 4]};
      gload[G_RPA] = is_preall & is_ddr2;
      gval[G_RPA] = {4'h0, powerdown_window[F_PRECHARGE_ALL +: 4]};
      gload[G_RRD] = is_act;
      gval[G_RRD] = {4'h0, row_column[F_BANK_TO_BANK +: 4]};
      gload[G_RC] = is_act;
      gval[G_RC] = {4'h0, row_column[F_ACT_TO_REFRESH +: 4]};
      gload[G_MRD] = is_mrs;
      gval[G_MRD] = {4'h0, row_column[F_MODE_LOAD +: 4]};
      gload[G_RFC] = is_ref;
      gval[G_RFC] = {3'h0, refresh_exit[F_REFRESH_CYCLE +: 5]};
      gload[G_XSNR] = sr_exit;
      gval[G_XSNR] = refresh_exit[F_SELFREF_NONREAD +: 8];
      gload[G_XSRD] = sr_exit & lp_or_ddr2;
      gval[G_XSRD] = refresh_exit[F_SELFREF_READ +: 8];
      gload[G_XP] = pd_exit & lp_or_ddr2;
      gval[G_XP] = {4'h0, refresh_exit[F_POWERDOWN_EXIT +: 4]};
      gload[G_XARD] = pd_exit & is_ddr2;
      gval[G_XARD] = control[F_APD_SLOW_SEL] ? {4'h0, powerdown_window[F_APD_SLOW +: 4]} :
                     {4'h0, powerdown_window[F_APD_FAST +: 4]};
      gload[G_WTR] = is_wr & lp_or_ddr2;
      gval[G_WTR] = wtr_gap;
   end

   for (genvar g = 0; g < G_NUM; g++) begin : g_global
      assign gnext[g] = count_next(gcnt[g], gload[g], gval[g]);
      always_ff @(posedge CLK_IN or posedge RST_IN) begin
         if (RST_IN) begin
            gcnt[g] <= 8'h00;
         end else begin
            gcnt[g] <= gnext[g];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // per-bank counters

   logic [7:0] bnext [NUM_BANKS][B_NUM];
   logic [NUM_BANKS-1:0] bank_pre_ok;
   logic [NUM_BANKS-1:0] bank_col_ok;

   for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
      logic [7:0] bcnt [B_NUM];
      logic hit;
      assign hit = (BANK_IN == 3'(b));
      assign bnext[b][B_RAS] = count_next(bcnt[B_RAS], is_act & hit,
                                          {4'h0, row_column[F_ACT_TO_PRE +: 4]});
      assign bnext[b][B_RCD] = count_next(bcnt[B_RCD], is_act & hit,
                                          {4'h0, row_column[F_ROW_TO_COL +: 4]});
      assign bnext[b][B_WR] = count_next(bcnt[B_WR], is_wr & hit,
                                         {4'h0, row_column[F_WRITE_RECOVERY +: 4]});
      assign bnext[b][B_RTP] = count_next(bcnt[B_RTP], is_rd & hit,
                                          {5'h00, powerdown_window[F_READ_TO_PRE +: 3]});
      assign bank_pre_ok[b] = (bnext[b][B_RAS] == 8'h00) && (bnext[b][B_WR] == 8'h00) &&
                              (bnext[b][B_RTP] == 8'h00);
      assign bank_col_ok[b] = (bnext[b][B_RCD] == 8'h00);
      always_ff @(posedge CLK_IN or posedge RST_IN) begin
         if (RST_IN) begin
            bcnt <= '{default: 8'h00};
         end else begin
            bcnt <= bnext[b];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // four-activate window: one slot per recent activate

   logic [7:0] fcnt [FAW_SLOTS];
   logic [7:0] fnext [FAW_SLOTS];
   logic faw_ok;

   always_comb begin
      logic taken;
      logic [7:0] dec;
      taken = 1'b0;
      dec = 8'h00;
      faw_ok = 1'b0;
      for (int i = 0; i < FAW_SLOTS; i++) begin
         dec = (fcnt[i] != 8'h00) ? fcnt[i] - 8'h01 : 8'h00;
         fnext[i] = dec;
         if (is_act && faw_enable && !taken && dec == 8'h00) begin
            fnext[i] = {4'h0, powerdown_window[F_FOUR_ACT +: 4]};
            taken = 1'b1;
         end
         if (fnext[i] == 8'h00) begin
            faw_ok = 1'b1;
         end
      end
      if (!faw_enable) begin
         faw_ok = 1'b1;
      end
   end

   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         fcnt <= '{default: 8'h00};
      end else begin
         fcnt <= fnext;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // permissions, registered from next counter values

   logic blk_all;
   logic blk_nonrd;
   logic blk_rd;
   logic act_ok;
   logic ref_ok;

   assign blk_all = (gnext[G_RP] != 8'h00) || (gnext[G_RPA] != 8'h00) ||
                    (gnext[G_XP] != 8'h00);
   assign blk_nonrd = blk_all || (gnext[G_XSNR] != 8'h00);
   assign blk_rd = blk_all || (gnext[G_XSRD] != 8'h00) || (gnext[G_XARD] != 8'h00) ||
                   (gnext[G_WTR] != 8'h00);
   assign act_ok = !blk_nonrd && (gnext[G_RRD] == 8'h00) && (gnext[G_RFC] == 8'h00) &&
                   (gnext[G_MRD] == 8'h00) && faw_ok;
   assign ref_ok = !blk_nonrd && (gnext[G_RC] == 8'h00) && (gnext[G_RFC] == 8'h00) &&
                   (gnext[G_MRD] == 8'h00);

   // outputs come from flops so the scheduler sees a clean level
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         ALLOW_ACT_OUT <= 8'h00;
         ALLOW_RD_OUT <= 8'h00;
         ALLOW_WR_OUT <= 8'h00;
         ALLOW_PRE_OUT <= 8'h00;
         ALLOW_PREALL_OUT <= 1'b0;
         ALLOW_REF_OUT <= 1'b0;
         ALLOW_MRS_OUT <= 1'b0;
      end else begin
         ALLOW_ACT_OUT <= {NUM_BANKS{act_ok}};
         ALLOW_RD_OUT <= bank_col_ok & {NUM_BANKS{!blk_rd}};
         ALLOW_WR_OUT <= bank_col_ok & {NUM_BANKS{!blk_nonrd}};
         ALLOW_PRE_OUT <= bank_pre_ok & {NUM_BANKS{!blk_nonrd}};
         ALLOW_PREALL_OUT <= (&bank_pre_ok) & !blk_nonrd;
         ALLOW_REF_OUT <= ref_ok;
         ALLOW_MRS_OUT <= !blk_nonrd;
      end
   end

   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         ADDR_INTERLEAVE_OUT <= 1'b0;
         MEM_TYPE_OUT <= MT_SDR;
      end else begin
         ADDR_INTERLEAVE_OUT <= control[F_INTERLEAVE];
         MEM_TYPE_OUT <= memory_type_code;
      end
   end

   // status mirrors the permissions currently shown to the scheduler, except ALLOW_WR_OUT
   assign status = {ALLOW_RD_OUT, ALLOW_ACT_OUT, 5'h00, ALLOW_MRS_OUT, ALLOW_REF_OUT,
                    ALLOW_PREALL_OUT, ALLOW_PRE_OUT};

endmodule // stpe_timing_enforcer

// ===== stpe_timing_enforcer_assertions.sv
`timescale 1ns/1ps
module stpe_timing_enforcer_checker
   import stpe_pkg::*;
(
   // clock and reset
   input wire logic CLK_IN,
   input wire logic RST_IN,
   // register bus
   input wire logic [31:0] WB_ADR_IN,
   input wire logic [31:0] WB_DAT_IN,
   input wire logic WB_WE_IN,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic [31:0] WB_DAT_OUT,
   input wire logic WB_ACK_OUT,
   // scheduler link
   input wire logic CMD_VALID_IN,
   input wire logic [2:0] CMD_IN,
   input wire logic [2:0] BANK_IN,
   input wire logic [7:0] ALLOW_ACT_OUT,
   input wire logic [7:0] ALLOW_RD_OUT,
   input wire logic [7:0] ALLOW_WR_OUT,
   input wire logic [7:0] ALLOW_PRE_OUT,
   input wire logic ALLOW_REF_OUT,
   input wire logic ADDR_INTERLEAVE_OUT
);
   logic [31:0] tp0;
   logic [4:0] rfc;
   logic ilv;
   logic prot;
   wire wr_hit = WB_ACK_OUT && WB_WE_IN && WB_CYC_IN && WB_STB_IN;
   wire ctl_wr = wr_hit && WB_ADR_IN == ADDR_CONTROL;
   ////////////////////////////////////////////////////////////////////////////
   // shadow of the spacings; protected writes dropped
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         tp0 <= RST_ROW_COLUMN;
         rfc <= RST_REFRESH_EXIT[4:0];
      end else if (wr_hit && !prot) begin
         if (WB_ADR_IN == ADDR_ROW_COLUMN) tp0 <= WB_DAT_IN;
         if (WB_ADR_IN == ADDR_REFRESH_EXIT) rfc <= WB_DAT_IN[4:0];
      end
   end
   // control shadow, never protected
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         ilv <= 1'b0;
         prot <= 1'b0;
      end else if (ctl_wr) begin
         ilv <= WB_DAT_IN[0];
         prot <= WB_DAT_IN[16];
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);
   // a command whose spacing is long enough to be seen one cycle later
   sequence s_cmd(c, f);
      CMD_VALID_IN && CMD_IN == c && f > 1;
   endsequence
   sequence s_shut;
      ALLOW_ACT_OUT == 8'h00 && !ALLOW_REF_OUT;
   endsequence
   a_ack_answer: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
      else $error("bus request not answered");
   a_ack_single: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
      else $error("ack longer than one cycle");
   a_data_quiet: assert property (!WB_ACK_OUT |-> WB_DAT_OUT == 32'h0)
      else $error("read data outside ack");
   a_decode_follow: assert property (ctl_wr |-> ##[1:2] ADDR_INTERLEAVE_OUT == ilv)
      else $error("decoding select not updated");
   a_ras_block: assert property (s_cmd(CMD_ACTIVATE, tp0[3:0]) |=>
      !ALLOW_PRE_OUT[$past(BANK_IN)]) else $error("precharge allowed after activate");
   a_rcd_block: assert property (s_cmd(CMD_ACTIVATE, tp0[7:4]) |=>
      !ALLOW_RD_OUT[$past(BANK_IN)] && !ALLOW_WR_OUT[$past(BANK_IN)])
      else $error("column access allowed after activate");
   a_rc_block: assert property (s_cmd(CMD_ACTIVATE, tp0[15:12]) |=> !ALLOW_REF_OUT)
      else $error("refresh allowed after activate");
   a_rp_block: assert property (s_cmd(CMD_PRECHARGE, tp0[19:16]) |=> s_shut)
      else $error("command allowed after precharge");
   a_rrd_block: assert property (s_cmd(CMD_ACTIVATE, tp0[23:20]) |=> ALLOW_ACT_OUT == 8'h00)
      else $error("activate allowed too soon");
   a_mrd_block: assert property (s_cmd(CMD_MODE_LOAD, tp0[31:28]) |=> s_shut)
      else $error("command allowed after mode load");
   a_rfc_block: assert property (s_cmd(CMD_REFRESH, rfc >> 1) |=> s_shut [*2])
      else $error("command allowed after refresh");
endmodule // stpe_timing_enforcer_checker

// ===== stpe_sdram_model.sv
`timescale 1ns/1ps
module stpe_sdram_model
   import stpe_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // commands on the memory pins
   input wire logic cmd_valid_in,
   input wire logic [2:0] cmd_in,
   input wire logic [2:0] bank_in,
   // permissions in force
   input wire logic [7:0] act_in,
   input wire logic [7:0] rd_in,
   input wire logic [7:0] wr_in,
   input wire logic [7:0] pre_in,
   input wire logic preall_in,
   input wire logic ref_in,
   input wire logic mrs_in,
   // commands taken before their spacing ran out
   output logic [7:0] err_out
);
   logic ok;
   always_comb begin
      case (cmd_in)
         CMD_ACTIVATE: ok = act_in[bank_in];
         CMD_READ: ok = rd_in[bank_in];
         CMD_WRITE: ok = wr_in[bank_in];
         CMD_PRECHARGE: ok = pre_in[bank_in];
         CMD_PRECHARGE_ALL: ok = preall_in;
         CMD_REFRESH: ok = ref_in;
         CMD_MODE_LOAD: ok = mrs_in;
         default: ok = 1'b1;
      endcase
   end
   // an early command corrupts a real part, so count each
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) err_out <= 8'h00;
      else if (cmd_valid_in && !ok) err_out <= err_out + 8'h01;
   end
endmodule // stpe_sdram_model

// ===== test_sdram_timing_parameter_enforcer.sv
`timescale 1ns/1ps
module test_sdram_timing_parameter_enforcer;
   import stpe_pkg::*;
   typedef struct {logic [2:0] c; int w; int n;} stpe_row_t;
   logic CLK_IN, RST_IN, we, cyc, stb, ack, cmd_v, cke, ilv, preall, refa, mrs;
   logic [31:0] adr, wdat, rdat;
   logic [3:0] sel;
   logic [2:0] cmd_c, bank, mtype;
   logic [1:0] kind;
   logic [7:0] a_act, a_rd, a_wr, a_pre, err;
   int bad_count, comparisons, cyc_n, n, t0;
   // trigger command, watched permission, expected spacing
   stpe_row_t rows [9] = '{'{CMD_ACTIVATE, 1, 4}, '{CMD_ACTIVATE, 2, 7},
      '{CMD_ACTIVATE, 3, 10}, '{CMD_ACTIVATE, 0, 4}, '{CMD_PRECHARGE, 0, 4},
      '{CMD_WRITE, 2, 5}, '{CMD_READ, 2, 6}, '{CMD_REFRESH, 3, 11}, '{CMD_MODE_LOAD, 0, 5}};
   stpe_timing_enforcer u_stpe_timing_enforcer (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
      .WB_ADR_IN(adr), .WB_DAT_IN(wdat), .WB_SEL_IN(sel), .WB_WE_IN(we), .WB_CYC_IN(cyc),
      .WB_STB_IN(stb), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .CMD_VALID_IN(cmd_v),
      .CMD_IN(cmd_c), .BANK_IN(bank), .CKE_RISE_IN(cke), .EXIT_KIND_IN(kind),
      .ALLOW_ACT_OUT(a_act), .ALLOW_RD_OUT(a_rd), .ALLOW_WR_OUT(a_wr), .ALLOW_PRE_OUT(a_pre),
      .ALLOW_PREALL_OUT(preall), .ALLOW_REF_OUT(refa), .ALLOW_MRS_OUT(mrs),
      .ADDR_INTERLEAVE_OUT(ilv), .MEM_TYPE_OUT(mtype));
   stpe_sdram_model u_stpe_sdram_model (.clk_in(CLK_IN), .rst_in(RST_IN), .cmd_valid_in(cmd_v),
      .cmd_in(cmd_c), .bank_in(bank), .act_in(a_act), .rd_in(a_rd), .wr_in(a_wr),
      .pre_in(a_pre), .preall_in(preall), .ref_in(refa), .mrs_in(mrs), .err_out(err));
   ////////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      if (bad_count == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one classic cycle; request held until ack is sampled high
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int t;
      t = 0;
      @(posedge CLK_IN);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge CLK_IN);
         t++;
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (t >= 20) chk("ack wait", 32'h0, 32'h1);
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk("read data", q, e);
   endtask
   function automatic logic pick(input int w);
      case (w)
         0: return a_act[1];
         1: return a_rd[0];
         2: return a_pre[0];
         default: return refa;
      endcase
   endfunction
   // kind 2 issues command c, else a clock-enable rise
   task automatic fire(input int k, input logic [2:0] c, input logic [2:0] b);
      cmd_v <= (k == 2);
      cke <= (k != 2);
      kind <= k[1:0];
      cmd_c <= c;
      bank <= b;
      @(posedge CLK_IN);
      cmd_v <= 1'b0;
      cke <= 1'b0;
   endtask
   task automatic wait_allow(input int w, output int m);
      m = 0;
      do begin
         @(posedge CLK_IN);
         m++;
      end while (pick(w) !== 1'b1 && m < 300);
   endtask
   task automatic step(input logic [31:0] ctl, input int k, input logic [2:0] c, input int w,
      output int m);
      wr(ADDR_CONTROL, ctl);
      fire(k, c, 3'h0);
      wait_allow(w, m);
      repeat (40) @(posedge CLK_IN);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // clock, and a cycle count that ends a hang
   initial begin
      CLK_IN = 1'b0;
      forever #25 CLK_IN = ~CLK_IN;
   end
   always @(posedge CLK_IN) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n > 6000) begin
         chk("timeout", 32'h1, 32'h0);
         finish_test();
      end
   end
   initial begin
      {RST_IN, we, cyc, stb, cmd_v, cke} = 6'b100000;
      {adr, wdat, cmd_c, bank, kind, sel} = {64'h0, 8'h0, 4'hf};
      {bad_count, comparisons, cyc_n} = {32'h0, 32'h0, 32'h0};
      repeat (12) @(posedge CLK_IN);
      RST_IN <= 1'b0;
      repeat (2) @(posedge CLK_IN);
      chk("allow act", a_act, 8'hff);
      chk("decoding", ilv, 1'b0);
      chk("memory type", mtype, MT_SDR);
      rd(ADDR_ROW_COLUMN, RST_ROW_COLUMN);
      rd(ADDR_REFRESH_EXIT, RST_REFRESH_EXIT);
      rd(ADDR_POWERDOWN_WINDOW, RST_POWERDOWN_WINDOW);
      rd(32'hffffe818, 32'h0);
      wr(ADDR_ROW_COLUMN, 32'h40339436);
      wr(ADDR_REFRESH_EXIT, 32'h030c080a);
      wr(ADDR_POWERDOWN_WINDOW, 32'h000f5765);
      rd(ADDR_ROW_COLUMN, 32'h40339436);
      foreach (rows[i]) begin
         fire(2, rows[i].c, 3'h0);
         wait_allow(rows[i].w, n);
         chk("spacing", n, rows[i].n);
         repeat (40) @(posedge CLK_IN);
      end
      wr(ADDR_CONTROL, 32'h00000201);
      rd(ADDR_CONTROL, 32'h00000201);
      chk("decoding", ilv, 1'b1);
      wr(ADDR_CONTROL, 32'h00010201);
      wr(ADDR_ROW_COLUMN, 32'h0);
      rd(ADDR_ROW_COLUMN, 32'h40339436);
      wr(ADDR_CONTROL, 32'h00000200);
      wr(ADDR_ROW_COLUMN, 32'h43319436);
      rd(ADDR_ROW_COLUMN, 32'h43319436);
      step(32'h00000200, 0, CMD_NOP, 0, n);
      chk("selfref nonread", n, 9);
      step(32'h00000200, 2, CMD_PRECHARGE_ALL, 0, n);
      chk("sdr precharge all", n, 2);
      step(32'h00000231, 2, CMD_WRITE, 1, n);
      chk("write to read", n, 4);
      step(32'h00000231, 1, CMD_NOP, 0, n);
      chk("powerdown exit", n, 4);
      step(32'h00000241, 1, CMD_NOP, 1, n);
      chk("slow exit read", n, 7);
      step(32'h00000041, 1, CMD_NOP, 1, n);
      chk("fast exit read", n, 6);
      step(32'h00000241, 0, CMD_NOP, 1, n);
      chk("selfref read", n, 13);
      step(32'h00000241, 2, CMD_PRECHARGE_ALL, 0, n);
      chk("precharge all", n, 8);
      wr(ADDR_ROW_COLUMN, 32'h48119436);
      step(32'h00000231, 2, CMD_WRITE, 1, n);
      chk("short gap", n, 1);
      chk("memory type", mtype, MT_LPDDR1);
      // four quick activates fill the window; the fifth waits
      step(32'h00000341, 1, CMD_NOP, 0, n);
      fire(2, CMD_ACTIVATE, 3'h0);
      t0 = cyc_n;
      for (int b = 1; b < 4; b++) begin
         wait_allow(0, n);
         fire(2, CMD_ACTIVATE, b[2:0]);
      end
      wait_allow(0, n);
      chk("four activate window", cyc_n - t0, 16);
      chk("early commands", err, 8'h00);
      finish_test();
   end
endmodule // test_sdram_timing_parameter_enforcer
bind stpe_timing_enforcer stpe_timing_enforcer_checker u_stpe_timing_enforcer_checker (
   .CLK_IN(CLK_IN), .RST_IN(RST_IN), .WB_ADR_IN(WB_ADR_IN), .WB_DAT_IN(WB_DAT_IN),
   .WB_WE_IN(WB_WE_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_DAT_OUT(WB_DAT_OUT),
   .WB_ACK_OUT(WB_ACK_OUT), .CMD_VALID_IN(CMD_VALID_IN), .CMD_IN(CMD_IN), .BANK_IN(BANK_IN),
   .ALLOW_ACT_OUT(ALLOW_ACT_OUT), .ALLOW_RD_OUT(ALLOW_RD_OUT), .ALLOW_WR_OUT(ALLOW_WR_OUT),
   .ALLOW_PRE_OUT(ALLOW_PRE_OUT), .ALLOW_REF_OUT(ALLOW_REF_OUT),
   .ADDR_INTERLEAVE_OUT(ADDR_INTERLEAVE_OUT));
